// >>> logic/baud_clock_multiplier.sv
// Times-four tick multiplier that feeds the baud rate generator of one channel.
`timescale 1ns/1ps
module baud_clock_multiplier
   import serial_channel_extra_config_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   mult_if.mult m
);
   import serial_channel_extra_config_pkg::*;

   typedef struct packed {
      logic [PERIOD_W-1:0] period;
      logic [PERIOD_W-1:0] count;
      logic [PERIOD_W-1:0] phase;
      logic [1:0] extra;
      logic seen;
      logic locked;
   } mult_state_t;

   mult_state_t st_ff;
   mult_state_t nxt_st;
   logic [PERIOD_W-1:0] quarter;

   // The period is measured in system clocks, so source periods under four clocks cannot
   // be multiplied; the input range limit on software keeps well inside that.
   assign quarter = st_ff.period >> 2;

   always_comb begin
      nxt_st = st_ff;
      if (m.hold) begin
         nxt_st = '0;
      end else begin
         if (st_ff.count != PERIOD_MAX) begin
            nxt_st.count = st_ff.count + 8'h01;
         end
         if (st_ff.phase != PERIOD_MAX) begin
            nxt_st.phase = st_ff.phase + 8'h01;
         end
         if (st_ff.locked && st_ff.extra != 2'h0 && st_ff.phase == quarter) begin
            nxt_st.extra = st_ff.extra - 2'h1;
            nxt_st.phase = 8'h01;
         end
         if (m.src_tick) begin
            nxt_st.seen = 1'b1;
            nxt_st.count = 8'h01;
            nxt_st.phase = 8'h01;
            nxt_st.extra = 2'(MULT_FACTOR - 1);
            if (st_ff.seen) begin
               nxt_st.period = st_ff.count;
               nxt_st.locked = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // Bypass when times four is off; the multiplier output only counts while it runs.
   assign m.out_tick = !m.times_four ? m.src_tick :
      (!m.hold && st_ff.locked && (m.src_tick ||
      (st_ff.extra != 2'h0 && st_ff.phase == quarter)));
   assign m.locked = st_ff.locked;
endmodule : baud_clock_multiplier

// >>> logic/mult_if.sv
// Interface between the register bank and one channel clock multiplier.
`timescale 1ns/1ps
interface mult_if;
   logic src_tick;
   logic hold;
   logic times_four;
   logic out_tick;
   logic locked;
   modport bank (output src_tick, output hold, output times_four,
      input out_tick, input locked);
   modport mult (input src_tick, input hold, input times_four,
      output out_tick, output locked);
endinterface : mult_if

// >>> logic/serial_channel_extra_config.sv
// Bits 31 to 14 of the per-channel extra configuration register and the logic they steer.
`timescale 1ns/1ps
module serial_channel_extra_config
   import serial_channel_extra_config_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [serial_channel_extra_config_pkg::ADDR_W-1:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [serial_channel_extra_config_pkg::BYTES-1:0] reg_be,
   input wire logic [serial_channel_extra_config_pkg::DATA_W-1:0] reg_wdata,
   output logic [serial_channel_extra_config_pkg::DATA_W-1:0] reg_rdata,
   output logic reg_ack,
   output logic reg_hit,
   input wire logic [serial_channel_extra_config_pkg::NUM_CH-1:0] rts_request,
   input wire logic [serial_channel_extra_config_pkg::NUM_CH-1:0] force_rts_bit,
   input wire logic [serial_channel_extra_config_pkg::NUM_CH-1:0] tx_clk_tick,
   output logic [serial_channel_extra_config_pkg::NUM_CH-1:0] rts_out,
   input wire logic [serial_channel_extra_config_pkg::NUM_CH-1:0]
      [serial_channel_extra_config_pkg::LEVEL_W-1:0] tx_fifo_level,
   output logic [serial_channel_extra_config_pkg::NUM_CH-1:0]
      [serial_channel_extra_config_pkg::LEVEL_W-1:0] tx_fifo_limit,
   output logic [serial_channel_extra_config_pkg::NUM_CH-1:0] tx_fifo_accept,
   input wire logic [serial_channel_extra_config_pkg::NUM_CH-1:0] rx_bit_valid,
   input wire logic [serial_channel_extra_config_pkg::NUM_CH-1:0] rx_bit,
   output logic [serial_channel_extra_config_pkg::NUM_CH-1:0][7:0] rx_byte,
   output logic [serial_channel_extra_config_pkg::NUM_CH-1:0] rx_byte_valid,
   input wire logic [serial_channel_extra_config_pkg::NUM_CH-1:0] carrier_pin_in,
   output logic [serial_channel_extra_config_pkg::NUM_CH-1:0] carrier_pin_out,
   output logic [serial_channel_extra_config_pkg::NUM_CH-1:0] carrier_pin_oe,
   output logic [serial_channel_extra_config_pkg::NUM_CH-1:0] carrier_detect,
   input wire logic [serial_channel_extra_config_pkg::NUM_CH-1:0] src_clk_tick,
   output logic [serial_channel_extra_config_pkg::NUM_CH-1:0] baud_clk_tick,
   output logic [serial_channel_extra_config_pkg::NUM_CH-1:0] multiplier_locked
);
   import serial_channel_extra_config_pkg::*;

   typedef struct packed {
      logic ok;
      logic [1:0] idx;
   } chan_sel_t;

   typedef struct packed {
      chan_cfg_t [NUM_CH-1:0] cfg;
      logic [NUM_CH-1:0] rts;
      logic [DATA_W-1:0] rdata;
      logic ack;
      logic hit;
   } bank_state_t;

   bank_state_t st_ff;
   bank_state_t nxt_st;
   chan_sel_t sel;
   logic [DATA_W-1:0] merged;

   // Maps a byte address onto a channel; anything else is unmapped.
   function automatic chan_sel_t decode_chan(input logic [ADDR_W-1:0] addr);
      chan_sel_t s;
      s = '0;
      for (int i = 0; i < NUM_CH; i++) begin
         if (addr == EXTRA_CONFIG_OFFSET[i]) begin
            s.ok = 1'b1;
            s.idx = 2'(i);
         end
      end
      return s;
   endfunction : decode_chan

   // Places the stored fields at their word positions; all other bits read as zero.
   function automatic logic [DATA_W-1:0] cfg_to_word(input chan_cfg_t c);
      logic [DATA_W-1:0] w;
      w = WORD_RESET;
      w[BIT_TX_FIFO_SHALLOW] = c.tx_fifo_shallow;
      w[BIT_DIRECT_RTS] = c.direct_rts_mode;
      w[BIT_RX_ORDER] = c.transparent_rx_bit_order;
      w[BIT_TERMINAL_READY] = c.terminal_ready_ch3;
      w[BIT_CARRIER_OUT] = c.carrier_pin_out_value;
      w[BIT_CARRIER_DIR] = c.carrier_pin_direction;
      w[BIT_MULT_HOLD] = c.multiplier_hold_reset;
      w[BIT_TIMES_FOUR] = c.baud_clock_times_four;
      return w;
   endfunction : cfg_to_word

   // Only the stored field bits are taken back, so reserved bits drop writes.
   function automatic chan_cfg_t word_to_cfg(input logic [DATA_W-1:0] w);
      chan_cfg_t c;
      c.tx_fifo_shallow = w[BIT_TX_FIFO_SHALLOW];
      c.direct_rts_mode = w[BIT_DIRECT_RTS];
      c.transparent_rx_bit_order = w[BIT_RX_ORDER];
      c.terminal_ready_ch3 = w[BIT_TERMINAL_READY];
      c.carrier_pin_out_value = w[BIT_CARRIER_OUT];
      c.carrier_pin_direction = w[BIT_CARRIER_DIR];
      c.multiplier_hold_reset = w[BIT_MULT_HOLD];
      c.baud_clock_times_four = w[BIT_TIMES_FOUR];
      return c;
   endfunction : word_to_cfg

   assign sel = decode_chan(reg_addr);

   always_comb begin
      merged = cfg_to_word(st_ff.cfg[sel.idx]);
      for (int b = 0; b < BYTES; b++) begin
         if (reg_be[b]) begin
            merged[8*b +: 8] = reg_wdata[8*b +: 8];
         end
      end
   end

   always_comb begin
      nxt_st = st_ff;
      nxt_st.ack = 1'b0;
      if (reg_wr && sel.ok) begin
         nxt_st.cfg[sel.idx] = word_to_cfg(merged);
      end
      if (reg_rd || reg_wr) begin
         nxt_st.ack = 1'b1;
         nxt_st.hit = sel.ok;
      end
      if (reg_rd) begin
         nxt_st.rdata = sel.ok ? cfg_to_word(st_ff.cfg[sel.idx]) : WORD_RESET;
      end
      for (int ch = 0; ch < NUM_CH; ch++) begin
         if (st_ff.cfg[ch].direct_rts_mode) begin
            // No transmit clock is needed, so the line can be set up while idle.
            nxt_st.rts[ch] = force_rts_bit[ch];
         end else if (tx_clk_tick[ch]) begin
            // The normal path only moves on transmit clock ticks and freezes without them.
            nxt_st.rts[ch] = rts_request[ch] | force_rts_bit[ch];
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         for (int ch = 0; ch < NUM_CH; ch++) begin
            st_ff.cfg[ch] <= CFG_RESET;
         end
         st_ff.rts <= '0;
         st_ff.rdata <= WORD_RESET;
         st_ff.ack <= 1'b0;
         st_ff.hit <= 1'b0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign reg_rdata = st_ff.rdata;
   assign reg_ack = st_ff.ack;
   assign reg_hit = st_ff.hit;
   assign rts_out = st_ff.rts;

   mult_if mif [NUM_CH] ();

   for (genvar g = 0; g < NUM_CH; g++) begin : gen_chan
      // The limit counts the two shift stages as well as the FIFO storage.
      assign tx_fifo_limit[g] = st_ff.cfg[g].tx_fifo_shallow ?
         DEPTH_SHALLOW : DEPTH_DEEP;
      assign tx_fifo_accept[g] = tx_fifo_level[g] < tx_fifo_limit[g];

      assign carrier_pin_oe[g] = st_ff.cfg[g].carrier_pin_direction;
      assign carrier_pin_out[g] = st_ff.cfg[g].carrier_pin_direction &
         st_ff.cfg[g].carrier_pin_out_value;
      // When driving, the sensed carrier is the driven value, not the pin input.
      assign carrier_detect[g] = st_ff.cfg[g].carrier_pin_direction ?
         st_ff.cfg[g].carrier_pin_out_value : carrier_pin_in[g];

      assign mif[g].src_tick = src_clk_tick[g];
      assign mif[g].hold = st_ff.cfg[g].multiplier_hold_reset;
      assign mif[g].times_four = st_ff.cfg[g].baud_clock_times_four;
      assign baud_clk_tick[g] = mif[g].out_tick;
      assign multiplier_locked[g] = mif[g].locked;

      baud_clock_multiplier u_mult (
         .clk(clk),
         .reset_n(reset_n),
         .m(mif[g])
      );

      transparent_rx_assembler u_rx (
         .clk(clk),
         .reset_n(reset_n),
         .msb_first(st_ff.cfg[g].transparent_rx_bit_order),
         .bit_valid(rx_bit_valid[g]),
         .bit_value(rx_bit[g]),
         .byte_data(rx_byte[g]),
         .byte_valid(rx_byte_valid[g])
      );
   end
endmodule : serial_channel_extra_config

// >>> logic/serial_channel_extra_config_pkg.sv
// Constants, field layout and types of the per-channel extra configuration register.
// Summary of operation
// - Bits 31 to 22 read as zero and ignore writes.
// - Shallow bit 21 limits the transmit FIFO to 2+2 bytes, else 16+2 bytes.
// - With bit 20 clear, RTS follows request and force bits, updated by transmit clock.
// - With bit 20 set, RTS follows the force bit directly, no transmit clock needed.
// - Bit 19 clear: transparent receive bytes are LSB first, first bit at 0.
// - Bit 19 set: transparent receive bytes are MSB first, first bit at 7.
// - Bit 18 is plain read/write storage driving no pin.
// - Bit 15 set holds the clock multiplier in reset; clear lets it run.
// - Bit 14 set multiplies the baud generator input clock by four; clear bypasses.
package serial_channel_extra_config_pkg;
   localparam int NUM_CH = 4;
   localparam int ADDR_W = 10;
   localparam int DATA_W = 32;
   localparam int BYTES = 4;
   localparam logic [ADDR_W-1:0] EXTRA_CONFIG_OFFSET [NUM_CH] = '{
      10'h15c, 10'h1dc, 10'h25c, 10'h2dc};
   localparam int BIT_TX_FIFO_SHALLOW = 21;
   localparam int BIT_DIRECT_RTS = 20;
   localparam int BIT_RX_ORDER = 19;
   localparam int BIT_TERMINAL_READY = 18;
   localparam int BIT_CARRIER_OUT = 17;
   localparam int BIT_CARRIER_DIR = 16;
   localparam int BIT_MULT_HOLD = 15;
   localparam int BIT_TIMES_FOUR = 14;
   localparam int FIELD_LSB = 14;
   localparam int FIELD_W = 8;
   localparam int LEVEL_W = 5;
   localparam int DEEP_DATA_BYTES = 16;
   localparam int SHALLOW_DATA_BYTES = 2;
   localparam int SHIFT_STAGE_BYTES = 2;
   localparam logic [LEVEL_W-1:0] DEPTH_DEEP = LEVEL_W'(DEEP_DATA_BYTES + SHIFT_STAGE_BYTES);
   localparam logic [LEVEL_W-1:0] DEPTH_SHALLOW =
      LEVEL_W'(SHALLOW_DATA_BYTES + SHIFT_STAGE_BYTES);
   localparam int MULT_FACTOR = 4;
   localparam int PERIOD_W = 8;
   localparam logic [PERIOD_W-1:0] PERIOD_MAX = 8'hff;
   localparam logic [2:0] BITS_PER_BYTE_LAST = 3'h7;
   localparam logic [DATA_W-1:0] WORD_RESET = 32'h0000_0000;

   typedef struct packed {
      logic tx_fifo_shallow;
      logic direct_rts_mode;
      logic transparent_rx_bit_order;
      logic terminal_ready_ch3;
      logic carrier_pin_out_value;
      logic carrier_pin_direction;
      logic multiplier_hold_reset;
      logic baud_clock_times_four;
   } chan_cfg_t;

   localparam chan_cfg_t CFG_RESET = '0;
endpackage : serial_channel_extra_config_pkg

// >>> logic/transparent_rx_assembler.sv
// Packs extended transparent receive bits into bytes in either bit order.
`timescale 1ns/1ps
module transparent_rx_assembler
   import serial_channel_extra_config_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic msb_first,
   input wire logic bit_valid,
   input wire logic bit_value,
   output logic [7:0] byte_data,
   output logic byte_valid
);
   import serial_channel_extra_config_pkg::*;

   typedef struct packed {
      logic [7:0] shift;
      logic [2:0] count;
      logic [7:0] data;
      logic valid;
   } asm_state_t;

   asm_state_t st_ff;
   asm_state_t nxt_st;
   logic [7:0] shifted;

   always_comb begin
      shifted = msb_first ? {st_ff.shift[6:0], bit_value} :
         {bit_value, st_ff.shift[7:1]};
      nxt_st = st_ff;
      nxt_st.valid = 1'b0;
      if (bit_valid) begin
         nxt_st.shift = shifted;
         nxt_st.count = st_ff.count + 3'h1;
         if (st_ff.count == BITS_PER_BYTE_LAST) begin
            nxt_st.data = shifted;
            nxt_st.valid = 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign byte_data = st_ff.data;
   assign byte_valid = st_ff.valid;
endmodule : transparent_rx_assembler

// >>> verif/line_partner_model.sv
// Far-end line model: free-running source clock ticks and a serial receive bit stream.
`timescale 1ns/1ps
module line_partner_model (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [7:0] data,
   input wire logic go,
   output logic bit_valid,
   output logic bit_val,
   output logic src_tick,
   output logic busy
);
   logic [3:0] n;
   logic [7:0] sh;
   logic ph;
   logic [2:0] div;
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         {n, sh, ph, div, bit_valid, bit_val, src_tick} <= '0;
      end else begin
         div <= div + 3'h1;
         // Eight clocks per tick stand for a source clock inside the permitted input range.
         src_tick <= (div == 3'h7);
         ph <= ~ph;
         bit_valid <= 1'b0;
         if (go && n == 4'h0) begin
            sh <= data;
            n <= 4'h8;
         end else if (n != 4'h0 && ph) begin
            bit_valid <= 1'b1;
            bit_val <= sh[0];
            sh <= sh >> 1;
            n <= n - 4'h1;
         end else begin
            // The bit line is not qualified here, so keep it moving to expose late sampling.
            bit_val <= ~bit_val;
         end
      end
   end
   assign busy = (n != 4'h0) || bit_valid;
endmodule : line_partner_model

// >>> verif/serial_channel_extra_config_monitor.sv
// Port checker for the extra configuration register block.
`timescale 1ns/1ps
module serial_channel_extra_config_monitor
   import serial_channel_extra_config_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [DATA_W-1:0] reg_rdata,
   input wire logic reg_ack,
   input wire logic reg_hit,
   input wire logic reg_rd,
   input wire logic [NUM_CH-1:0] rts_request,
   input wire logic [NUM_CH-1:0] force_rts_bit,
   input wire logic [NUM_CH-1:0] tx_clk_tick,
   input wire logic [NUM_CH-1:0] rts_out,
   input wire logic [NUM_CH-1:0][LEVEL_W-1:0] tx_fifo_level,
   input wire logic [NUM_CH-1:0][LEVEL_W-1:0] tx_fifo_limit,
   input wire logic [NUM_CH-1:0] tx_fifo_accept,
   input wire logic [NUM_CH-1:0] rx_bit_valid,
   input wire logic [NUM_CH-1:0] rx_byte_valid,
   input wire logic [NUM_CH-1:0] carrier_pin_in,
   input wire logic [NUM_CH-1:0] carrier_pin_out,
   input wire logic [NUM_CH-1:0] carrier_pin_oe,
   input wire logic [NUM_CH-1:0] carrier_detect,
   input wire logic [NUM_CH-1:0] src_clk_tick,
   input wire logic [NUM_CH-1:0] baud_clk_tick,
   input wire logic [NUM_CH-1:0] multiplier_locked
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   chk_rsvd_read_zero: assert property (reg_ack |-> reg_rdata[31:22] == '0)
      else $error("reserved bits not zero");
   // Read data holds across writes, so only an acknowledged read of a hole must be zero.
   chk_unmapped_read_zero: assert property
      (reg_ack && !reg_hit && $past(reg_rd) |-> reg_rdata == '0)
      else $error("unmapped read not zero");
   chk_fifo_limit_value: assert property
      (tx_fifo_limit[0] == 5'h12 || tx_fifo_limit[0] == 5'h04)
      else $error("fifo limit not a legal depth");
   chk_fifo_accept_level: assert property
      (tx_fifo_accept[0] == (tx_fifo_level[0] < tx_fifo_limit[0]))
      else $error("fifo accept wrong");
   chk_rts_force_high: assert property
      (tx_clk_tick[0] && force_rts_bit[0] |=> rts_out[0])
      else $error("rts not raised by force");
   chk_rts_all_low: assert property
      (tx_clk_tick[0] && !rts_request[0] && !force_rts_bit[0] |=> !rts_out[0])
      else $error("rts raised without cause");
   chk_rts_quiet_hold: assert property
      (!tx_clk_tick[0] && !force_rts_bit[0] && !rts_out[0] |=> !rts_out[0])
      else $error("rts rose without tick or force");
   chk_carrier_drive_dir: assert property (carrier_pin_out[0] |-> carrier_pin_oe[0])
      else $error("carrier driven while input");
   chk_carrier_seen_level: assert property
      (carrier_detect[0] == (carrier_pin_oe[0] ? carrier_pin_out[0] : carrier_pin_in[0]))
      else $error("carrier detect wrong source");
   chk_rx_byte_cause: assert property (rx_byte_valid[0] |-> $past(rx_bit_valid[0]))
      else $error("rx byte without a bit");
   chk_baud_tick_source: assert property
      (baud_clk_tick[0] |-> src_clk_tick[0] || multiplier_locked[0])
      else $error("baud tick without source");
   cover property (rx_byte_valid[0]);
   cover property ($rose(multiplier_locked[0]));
   cover property (reg_ack && carrier_pin_oe[0]);
endmodule : serial_channel_extra_config_monitor

bind serial_channel_extra_config serial_channel_extra_config_monitor i_mon (
   .clk(clk),
   .reset_n(reset_n),
   .reg_rdata(reg_rdata),
   .reg_ack(reg_ack),
   .reg_hit(reg_hit),
   .reg_rd(reg_rd),
   .rts_request(rts_request),
   .force_rts_bit(force_rts_bit),
   .tx_clk_tick(tx_clk_tick),
   .rts_out(rts_out),
   .tx_fifo_level(tx_fifo_level),
   .tx_fifo_limit(tx_fifo_limit),
   .tx_fifo_accept(tx_fifo_accept),
   .rx_bit_valid(rx_bit_valid),
   .rx_byte_valid(rx_byte_valid),
   .carrier_pin_in(carrier_pin_in),
   .carrier_pin_out(carrier_pin_out),
   .carrier_pin_oe(carrier_pin_oe),
   .carrier_detect(carrier_detect),
   .src_clk_tick(src_clk_tick),
   .baud_clk_tick(baud_clk_tick),
   .multiplier_locked(multiplier_locked)
);

// >>> verif/serial_channel_extra_config_tb.sv
// Self-checking testbench of the extra configuration register block.
`timescale 1ns/1ps
module serial_channel_extra_config_tb;
   import serial_channel_extra_config_pkg::*;
   logic clk = 0, reset_n = 0, reg_wr = 0, reg_rd = 0, go = 0, bv, bval, stick, busy;
   logic [ADDR_W-1:0] reg_addr = '0;
   logic [BYTES-1:0] reg_be = '0;
   logic [DATA_W-1:0] reg_wdata = '0, reg_rdata, w, sh[NUM_CH];
   logic reg_ack, reg_hit;
   logic [NUM_CH-1:0] rts_request = '0, force_rts_bit = '0, tx_clk_tick = '0, far = '0;
   logic [NUM_CH-1:0] rts_out, tx_fifo_accept, rx_bit_valid, rx_bit, rx_byte_valid;
   logic [NUM_CH-1:0] carrier_pin_in, carrier_pin_out, carrier_pin_oe, carrier_detect;
   logic [NUM_CH-1:0] src_clk_tick, baud_clk_tick, multiplier_locked;
   logic [NUM_CH-1:0][LEVEL_W-1:0] tx_fifo_level = '0, tx_fifo_limit;
   logic [NUM_CH-1:0][7:0] rx_byte;
   logic [7:0] d, x;
   logic [33:0] rq[$], e;
   logic [7:0] xq[$];
   int err_total = 0, checked = 0, n;
   always #50 clk = ~clk;
   assign rx_bit_valid = {NUM_CH{bv}};
   assign rx_bit = {NUM_CH{bval}};
   assign src_clk_tick = {NUM_CH{stick}};
   assign carrier_pin_in = (carrier_pin_oe & carrier_pin_out) | (~carrier_pin_oe & far);
   serial_channel_extra_config i_dut (
      .clk(clk),
      .reset_n(reset_n),
      .reg_addr(reg_addr),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .reg_be(reg_be),
      .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata),
      .reg_ack(reg_ack),
      .reg_hit(reg_hit),
      .rts_request(rts_request),
      .force_rts_bit(force_rts_bit),
      .tx_clk_tick(tx_clk_tick),
      .rts_out(rts_out),
      .tx_fifo_level(tx_fifo_level),
      .tx_fifo_limit(tx_fifo_limit),
      .tx_fifo_accept(tx_fifo_accept),
      .rx_bit_valid(rx_bit_valid),
      .rx_bit(rx_bit),
      .rx_byte(rx_byte),
      .rx_byte_valid(rx_byte_valid),
      .carrier_pin_in(carrier_pin_in),
      .carrier_pin_out(carrier_pin_out),
      .carrier_pin_oe(carrier_pin_oe),
      .carrier_detect(carrier_detect),
      .src_clk_tick(src_clk_tick),
      .baud_clk_tick(baud_clk_tick),
      .multiplier_locked(multiplier_locked)
   );
   line_partner_model i_line (.clk(clk), .reset_n(reset_n), .data(d), .go(go),
      .bit_valid(bv), .bit_val(bval), .src_tick(stick), .busy(busy));
   task check(input string nm, input logic [31:0] s, input logic [31:0] ex);
      checked++;
      if (s !== ex) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", nm, ex, s);
      end
   endtask : check
   task results;
      // A missing acknowledge or byte would otherwise leave its expectation unchecked.
      check("reads_pending", rq.size(), 0);
      check("bytes_pending", xq.size(), 0);
      $display("comparisons %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : results
   task access(input logic wr, input int c, input logic [3:0] be, input logic [31:0] wd,
      input logic [32:0] ex);
      @(posedge clk);
      reg_addr <= (c < 0) ? 10'h100 : EXTRA_CONFIG_OFFSET[c];
      reg_be <= be;
      reg_wdata <= wd;
      reg_wr <= wr;
      reg_rd <= !wr;
      rq.push_back({c >= 0, ex});
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
   endtask : access
   task tick_pulse;
      @(posedge clk) tx_clk_tick <= '1;
      @(posedge clk) tx_clk_tick <= '0;
      @(negedge clk);
   endtask : tick_pulse
   task count16(input logic [31:0] ex);
      logic [31:0] cnt;
      // A four-state count lets an unknown tick show up as a mismatch.
      cnt = '0;
      repeat (16) @(negedge clk) cnt += 32'(baud_clk_tick[0]);
      check("baud_ticks", cnt, ex);
   endtask : count16
   always @(negedge clk) begin
      if (reg_ack) begin
         e = rq.pop_front();
         check("hit", 32'(reg_hit), 32'(e[33]));
         if (e[32]) check("rdata", reg_rdata, e[31:0]);
      end
      if (rx_byte_valid[0]) check("rx_byte", rx_byte[0], xq.pop_front());
   end
   initial begin
      void'($urandom(32'hc20de82c));
      repeat (16) @(posedge clk);
      reset_n <= 1'b1;
      for (int c = -1; c < NUM_CH; c++) access(0, c, 0, 0, {1'b1, WORD_RESET});
      $display("test reset values done");
      for (int c = 0; c < NUM_CH; c++) begin
         w = $urandom;
         x = 8'($urandom);
         sh[c] = WORD_RESET;
         for (int k = 0; k < BYTES; k++) if (x[k]) sh[c][8*k+:8] = w[8*k+:8];
         sh[c] &= 32'h003f_c000;
         tx_fifo_level[c] <= 5'($urandom_range(0, 20));
         far <= 4'($urandom);
         access(1, c, x[3:0], w, '0);
         access(0, c, 0, 0, {1'b1, sh[c]});
         @(negedge clk);
         check("limit", tx_fifo_limit[c], sh[c][21] ? 4 : 18);
         check("accept", tx_fifo_accept[c], tx_fifo_level[c] < (sh[c][21] ? 4 : 18));
         check("carrier_oe", carrier_pin_oe[c], sh[c][16]);
         check("carrier_out", carrier_pin_out[c], sh[c][16] & sh[c][17]);
         check("carrier", carrier_detect[c], sh[c][16] ? sh[c][17] : far[c]);
      end
      $display("test register fields done");
      access(1, 0, 4'h6, 0, '0);
      force_rts_bit <= '1;
      tick_pulse();
      check("rts", rts_out[0], 1);
      access(1, 0, 4'h4, 32'h0010_0000, '0);
      @(posedge clk) force_rts_bit <= '0;
      @(posedge clk);
      @(negedge clk);
      check("rts", rts_out[0], 0);
      rts_request <= '1;
      access(1, 0, 4'h4, 0, '0);
      repeat (3) @(negedge clk);
      check("rts", rts_out[0], 0);
      tick_pulse();
      check("rts", rts_out[0], 1);
      @(posedge clk) rts_request <= '0;
      tick_pulse();
      check("rts", rts_out[0], 0);
      $display("test rts done");
      for (int o = 0; o < 2; o++) begin
         access(1, 0, 4'h4, o ? 32'h0008_0000 : 0, '0);
         x = 8'($urandom);
         for (int k = 0; k < 8; k++) w[k] = x[o ? 7 - k : k];
         xq.push_back(w[7:0]);
         @(posedge clk);
         d <= x;
         go <= 1'b1;
         @(posedge clk) go <= 1'b0;
         @(negedge clk);
         for (n = 0; busy && n < 40; n++) @(negedge clk);
         if (n == 40) begin
            err_total++;
            results();
         end
         repeat (2) @(negedge clk);
      end
      $display("test rx order done");
      access(1, 0, 4'h2, 32'h0000_c000, '0);
      repeat (30) @(negedge clk);
      check("locked", multiplier_locked[0], 0);
      count16(0);
      access(1, 0, 4'h2, 32'h0000_4000, '0);
      for (n = 0; !multiplier_locked[0] && n < 100; n++) @(negedge clk);
      if (n == 100) begin
         err_total++;
         results();
      end
      count16(8);
      access(1, 0, 4'h2, 0, '0);
      count16(2);
      $display("test multiplier done");
      results();
   end
endmodule : serial_channel_extra_config_tb
